// >>> mdc_control_regs.sv
// Motor driver control register bank with overcurrent handling
// What this block does
// - Full-duty PWM frequency bit picks 20/40 kHz
// - Overvoltage level bit picks 34 V or 22 V
// - Overvoltage protection only while enable bit set
// - Temperature warning drives fault pin only if enabled
// - Driver-off bit enters low-power standby
// - Cycle-clear bit releases overcurrent on new PWM
// - Overcurrent must persist for selected deglitch time
// - Retry wait 5 ms or 500 ms
// - Fault option 0 latches, 1 auto-retries
// - Option 2 reports only, 3 does nothing
// - Recirculation bit picks brake or coast
// - Async rectification only when enabled
// - Sync rectification only when enabled
// - Two-bit sense amplifier gain select
// - Buck sequencing skipped when disable bit set
// - Buck current limit 600 mA or 150 mA
// - Two-bit buck output voltage select
// - Buck runs unless disable bit set
// - Overcurrent register resets to 10h
// - Fault-clear bit clears latched faults, self-clears
`include "mdc_defs.svh"
module mdc_control_regs
   import mdc_pkg::*;
#(
   parameter int unsigned RETRY_SHORT_CYCLES =
      `MDC_MS_TO_CYC(`MDC_RETRY_SHORT_MS),
   parameter int unsigned RETRY_LONG_CYCLES =
      `MDC_MS_TO_CYC(`MDC_RETRY_LONG_MS),
   parameter int unsigned RETRY_W = 26
)
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_sdi,
   output logic spi_sdo,
   output logic spi_sdo_oe,
   input wire logic pwm_in,
   input wire logic overcurrent_raw,
   input wire logic supply_over_raw,
   input wire logic temp_warning_raw,
   output logic fault_output_n,
   output logic full_duty_40k,
   output logic overvoltage_level_22v,
   output logic overvoltage_shutdown,
   output logic driver_standby,
   output logic overcurrent_level_24a,
   output logic drive_shutdown,
   output logic overcurrent_reported,
   output logic limit_recirculation_coast,
   output logic async_rectify_on,
   output logic sync_rectify_on,
   output logic [1:0] sense_amp_gain,
   output logic buck_sequencing_on,
   output logic buck_current_150ma,
   output logic [1:0] buck_voltage_sel,
   output logic buck_run
);
   mdc_link_if link ();

   mdc_byte_t supply_reg; // Supply protection configuration
   mdc_byte_t oc_reg; // Overcurrent and standby configuration
   mdc_byte_t limit_reg; // Limit, rectification and sense
   mdc_byte_t buck_reg; // Buck regulator configuration
   mdc_byte_t hall_reg; // Hall, brake and direction storage
   logic clear_reg; // Fault-clear pulse, reads back zero
   logic pwm_meta_reg; // PWM first stage
   logic pwm_s2_reg;
   logic pwm_s3_reg;
   logic pwm_reg; // Filtered PWM level
   logic pwm_prev_reg;
   logic pwm_rise; // New PWM cycle
   logic [7:0] deg_cnt_reg; // Cycles overcurrent has persisted
   logic [7:0] deg_limit; // Deglitch cycles for current code
   logic oc_trip; // Deglitched overcurrent event
   mdc_oc_state_e oc_state_reg;
   mdc_oc_mode_e oc_mode;
   logic [RETRY_W-1:0] retry_cnt_reg; // Retry wait countdown
   logic [RETRY_W-1:0] retry_load;
   logic oc_release; // Cycle-by-cycle release
   logic oc_report_reg; // Sticky overcurrent indication
   logic fault_n_reg;
   logic shutdown_reg;
   logic ov_fault_reg;
   logic wr_hit_clear;

   // Serial frame handling lives in its own module
   mdc_serial_port u_serial (
      .clock(clock),
      .reset_n(reset_n),
      .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n),
      .spi_sdi(spi_sdi),
      .spi_sdo(spi_sdo),
      .spi_sdo_oe(spi_sdo_oe),
      .link(link.serial)
   );

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   // Register writes; masks keep read-only reserved bits at zero
   always_ff @(posedge clock or negedge reset_n)
      if (!reset_n)
      begin
         supply_reg <= `MDC_RST_SUPPLY;
         oc_reg <= `MDC_RST_OC;
         limit_reg <= `MDC_RST_LIMIT;
         buck_reg <= `MDC_RST_BUCK;
         hall_reg <= `MDC_RST_HALL;
      end
      else if (link.wr_en)
      begin
         // Unmapped addresses fall through and are ignored
         unique case (link.addr)
            `MDC_OFS_SUPPLY: supply_reg <= link.wr_data & `MDC_WMASK_SUPPLY;
            `MDC_OFS_OC: oc_reg <= link.wr_data & `MDC_WMASK_OC;
            `MDC_OFS_LIMIT: limit_reg <= link.wr_data & `MDC_WMASK_LIMIT;
            `MDC_OFS_BUCK: buck_reg <= link.wr_data & `MDC_WMASK_BUCK;
            `MDC_OFS_HALL: hall_reg <= link.wr_data & `MDC_WMASK_HALL;
            default:
            begin
            end
         endcase
      end

   assign wr_hit_clear = link.wr_en && link.addr == `MDC_OFS_FAULT_CLR &&
      link.wr_data[`MDC_B_FAULT_CLR];

   // Fault clear is a one-cycle pulse; nothing stores it
   always_ff @(posedge clock or negedge reset_n)
      if (!reset_n)
         clear_reg <= 1'b0;
      else
         clear_reg <= wr_hit_clear;

   // Read mux; the clear bit and unmapped words read zero
   always_comb
   begin
      unique case (link.addr)
         `MDC_OFS_SUPPLY: link.rd_data = supply_reg;
         `MDC_OFS_OC: link.rd_data = oc_reg;
         `MDC_OFS_LIMIT: link.rd_data = limit_reg;
         `MDC_OFS_BUCK: link.rd_data = buck_reg;
         `MDC_OFS_HALL: link.rd_data = hall_reg;
         default: link.rd_data = 8'h00;
      endcase
   end

   // PWM pin filter; stage one feeds only stage two
   always_ff @(posedge clock or negedge reset_n)
      if (!reset_n)
      begin
         pwm_meta_reg <= 1'b0;
         pwm_s2_reg <= 1'b0;
         pwm_s3_reg <= 1'b0;
         pwm_reg <= 1'b0;
         pwm_prev_reg <= 1'b0;
      end
      else
      begin
         pwm_meta_reg <= pwm_in;
         pwm_s2_reg <= pwm_meta_reg;
         pwm_s3_reg <= pwm_s2_reg;
         if (pwm_s2_reg == pwm_s3_reg)
            pwm_reg <= pwm_s2_reg;
         pwm_prev_reg <= pwm_reg;
      end

   assign pwm_rise = pwm_reg && !pwm_prev_reg;
   assign oc_release = oc_reg[`MDC_B_OC_CBC] && pwm_rise;
   assign oc_mode = mdc_oc_mode_e'(oc_reg[`MDC_B_OC_MODE +: 2]);

   // Deglitch length per code, rounded up to whole cycles
   always_comb
   begin
      unique case (oc_reg[`MDC_B_OC_DEG +: 2])
         2'h0: deg_limit = 8'(`MDC_NS_TO_CYC(`MDC_DEG0_NS));
         2'h1: deg_limit = 8'(`MDC_NS_TO_CYC(`MDC_DEG1_NS));
         2'h2: deg_limit = 8'(`MDC_NS_TO_CYC(`MDC_DEG2_NS));
         2'h3: deg_limit = 8'(`MDC_NS_TO_CYC(`MDC_DEG3_NS));
      endcase
   end

   // Persistence counter; it saturates so one event trips once
   always_ff @(posedge clock or negedge reset_n)
      if (!reset_n)
         deg_cnt_reg <= 8'h00;
      else if (!overcurrent_raw)
         deg_cnt_reg <= 8'h00;
      else if (deg_cnt_reg < deg_limit)
         deg_cnt_reg <= deg_cnt_reg + 8'h01;

   assign oc_trip = overcurrent_raw && deg_cnt_reg == deg_limit - 8'h01;

   // Retry wait follows the retry-time bit at the moment of the trip
   assign retry_load = oc_reg[`MDC_B_OC_RETRY] ?
      RETRY_W'(RETRY_LONG_CYCLES - 1) :
      RETRY_W'(RETRY_SHORT_CYCLES - 1);

   // Overcurrent reaction state machine
   always_ff @(posedge clock or negedge reset_n)
      if (!reset_n)
      begin
         oc_state_reg <= MDC_ST_IDLE;
         retry_cnt_reg <= '0;
      end
      else
         unique case (oc_state_reg)
            MDC_ST_IDLE:
               if (oc_trip && oc_mode == MDC_OC_LATCH)
                  oc_state_reg <= MDC_ST_LATCHED;
               else if (oc_trip && oc_mode == MDC_OC_RETRY)
               begin
                  oc_state_reg <= MDC_ST_WAIT;
                  retry_cnt_reg <= retry_load;
               end
            MDC_ST_LATCHED:
               // Only a clear command or a new PWM cycle releases it
               if (clear_reg || oc_release)
                  oc_state_reg <= MDC_ST_IDLE;
            MDC_ST_WAIT:
               if (retry_cnt_reg == '0 || clear_reg || oc_release)
                  oc_state_reg <= MDC_ST_IDLE;
               else
                  retry_cnt_reg <= retry_cnt_reg - 1'b1;
            default:
               oc_state_reg <= MDC_ST_IDLE;
         endcase

   // Sticky report; a new event wins over a clear in the same cycle
   always_ff @(posedge clock or negedge reset_n)
      if (!reset_n)
         oc_report_reg <= 1'b0;
      else if (oc_trip && oc_mode != MDC_OC_IGNORE)
         oc_report_reg <= 1'b1;
      else if (clear_reg)
         oc_report_reg <= 1'b0;
      else if (oc_state_reg != MDC_ST_IDLE && oc_release)
         oc_report_reg <= 1'b0;

   // Registered protection outputs and the open fault pin level
   always_ff @(posedge clock or negedge reset_n)
      if (!reset_n)
      begin
         fault_n_reg <= 1'b1;
         shutdown_reg <= 1'b0;
         ov_fault_reg <= 1'b0;
      end
      else
      begin
         ov_fault_reg <= supply_over_raw && supply_reg[`MDC_B_OV_EN];
         shutdown_reg <= oc_state_reg != MDC_ST_IDLE;
         fault_n_reg <= !(oc_report_reg || ov_fault_reg ||
            (temp_warning_raw && supply_reg[`MDC_B_TEMP_REP]));
      end

   assign fault_output_n = fault_n_reg;
   assign drive_shutdown = shutdown_reg;
   assign overvoltage_shutdown = ov_fault_reg;
   assign overcurrent_reported = oc_report_reg;
   // Settings straight from the register flops
   assign full_duty_40k = supply_reg[`MDC_B_FULL_DUTY];
   assign overvoltage_level_22v = supply_reg[`MDC_B_OV_SEL];
   assign driver_standby = oc_reg[`MDC_B_DRIVER_OFF];
   assign overcurrent_level_24a = oc_reg[`MDC_B_OC_LVL];
   assign limit_recirculation_coast = limit_reg[`MDC_B_RECIRC];
   assign async_rectify_on = limit_reg[`MDC_B_ASYNC_RECT];
   assign sync_rectify_on = limit_reg[`MDC_B_SYNC_RECT];
   assign sense_amp_gain = limit_reg[`MDC_B_GAIN +: 2];
   assign buck_sequencing_on = !buck_reg[`MDC_B_BUCK_SEQ_DIS];
   assign buck_current_150ma = buck_reg[`MDC_B_BUCK_CURRENT_LIMIT];
   assign buck_voltage_sel = buck_reg[`MDC_B_BUCK_VSEL +: 2];
   assign buck_run = !buck_reg[`MDC_B_BUCK_DISABLE];

   // Steps of a fault-clear command
   sequence clear_cmd_s;
      wr_hit_clear;
   endsequence
   sequence clear_pulse_s;
      clear_reg ##1 !clear_reg;
   endsequence

   clear_pulse_a: assert property (clear_cmd_s |=> clear_pulse_s)
      else $error("fault clear did not pulse once");
   deglitch_time_a: assert property (oc_state_reg == MDC_ST_IDLE ##1
      oc_state_reg != MDC_ST_IDLE |-> $past(deg_cnt_reg) ==
      deg_limit - 8'h01)
      else $error("overcurrent acted before deglitch time");
   latch_hold_a: assert property (oc_state_reg == MDC_ST_LATCHED &&
      !clear_reg && !oc_release |=> oc_state_reg == MDC_ST_LATCHED)
      else $error("latched overcurrent released by itself");
   retry_end_a: assert property (oc_state_reg == MDC_ST_WAIT &&
      retry_cnt_reg == '0 |=> oc_state_reg == MDC_ST_IDLE)
      else $error("retry wait did not end");
   cbc_release_a: assert property (oc_state_reg != MDC_ST_IDLE &&
      oc_release |=> oc_state_reg == MDC_ST_IDLE ##1 !drive_shutdown)
      else $error("new PWM cycle did not release overcurrent");
   report_only_a: assert property (oc_state_reg == MDC_ST_IDLE && oc_trip &&
      oc_mode == MDC_OC_REPORT |=> oc_report_reg &&
      oc_state_reg == MDC_ST_IDLE)
      else $error("report-only overcurrent took action");
   ignore_mode_a: assert property (oc_state_reg == MDC_ST_IDLE && oc_trip &&
      oc_mode == MDC_OC_IGNORE && !oc_report_reg && !clear_reg |=>
      !oc_report_reg &&
      $stable(oc_state_reg))
      else $error("ignored overcurrent was reported");
   temp_report_a: assert property (!supply_reg[`MDC_B_TEMP_REP] &&
      !oc_report_reg && !ov_fault_reg |=> fault_output_n)
      else $error("temperature warning reported while disabled");
   ovp_gate_a: assert property (!supply_reg[`MDC_B_OV_EN] |=>
      !overvoltage_shutdown)
      else $error("overvoltage acted while disabled");
   ro_zero_a: assert property (buck_reg[7:6] == 2'h0 &&
      supply_reg[7] == 1'b0 && hall_reg[7:5] == 3'h0)
      else $error("read-only reserved bit set");
endmodule

// >>> mdc_defs.svh
// Offsets, field positions, reset values and timing counts of the bank
`ifndef MDC_DEFS_SVH
`define MDC_DEFS_SVH
// Register offsets on the serial configuration port
`define MDC_OFS_FAULT_CLR 6'h04
`define MDC_OFS_SUPPLY 6'h05
`define MDC_OFS_OC 6'h06
`define MDC_OFS_LIMIT 6'h07
`define MDC_OFS_BUCK 6'h08
`define MDC_OFS_HALL 6'h09
// Reset values
`define MDC_RST_SUPPLY 8'h46
`define MDC_RST_OC 8'h10
`define MDC_RST_LIMIT 8'h00
`define MDC_RST_BUCK 8'h00
`define MDC_RST_HALL 8'h01
// Writable bits; the rest read as zero
`define MDC_WMASK_SUPPLY 8'h7F
`define MDC_WMASK_OC 8'hFF
`define MDC_WMASK_LIMIT 8'hFF
`define MDC_WMASK_BUCK 8'h3F
`define MDC_WMASK_HALL 8'h1F
// Field positions
`define MDC_B_TEMP_REP 0
`define MDC_B_OV_EN 2
`define MDC_B_OV_SEL 3
`define MDC_B_FULL_DUTY 4
`define MDC_B_OC_MODE 0
`define MDC_B_OC_LVL 2
`define MDC_B_OC_RETRY 3
`define MDC_B_OC_DEG 4
`define MDC_B_OC_CBC 6
`define MDC_B_DRIVER_OFF 7
`define MDC_B_GAIN 0
`define MDC_B_SYNC_RECT 2
`define MDC_B_ASYNC_RECT 3
`define MDC_B_RECIRC 6
`define MDC_B_BUCK_DISABLE 0
`define MDC_B_BUCK_VSEL 1
`define MDC_B_BUCK_CURRENT_LIMIT 3
`define MDC_B_BUCK_SEQ_DIS 4
`define MDC_B_FAULT_CLR 0
// Timing: clock period, deglitch and retry times
`define MDC_CLK_NS 8
`define MDC_DEG0_NS 200
`define MDC_DEG1_NS 600
`define MDC_DEG2_NS 1250
`define MDC_DEG3_NS 1600
`define MDC_NS_TO_CYC(t) (((t) + `MDC_CLK_NS - 1) / `MDC_CLK_NS)
`define MDC_RETRY_SHORT_MS 5
`define MDC_RETRY_LONG_MS 500
`define MDC_MS_TO_CYC(t) ((t) * 1000000 / `MDC_CLK_NS)
// Serial frame layout
`define MDC_FRAME_BITS 16
`define MDC_HDR_BITS 8
`endif

// >>> mdc_pkg.sv
// Types shared by the control register bank files
package mdc_pkg;
   typedef logic [7:0] mdc_byte_t;
   typedef logic [5:0] mdc_addr_t;
   // Overcurrent reaction, in field code order
   typedef enum logic [1:0] {MDC_OC_LATCH, MDC_OC_RETRY, MDC_OC_REPORT,
      MDC_OC_IGNORE} mdc_oc_mode_e;
   // Overcurrent protection states
   typedef enum logic [1:0] {MDC_ST_IDLE, MDC_ST_LATCHED, MDC_ST_WAIT}
      mdc_oc_state_e;
endpackage

// >>> mdc_link_if.sv
// Internal register access link between serial port and bank
interface mdc_link_if;
   import mdc_pkg::*;
   mdc_addr_t addr; // Register address of the frame
   logic wr_en; // One-cycle write strobe
   mdc_byte_t wr_data; // Write data
   mdc_byte_t rd_data; // Read data for addr
   modport serial (output addr, output wr_en, output wr_data,
      input rd_data);
   modport bank (input addr, input wr_en, input wr_data,
      output rd_data);
endinterface

// >>> mdc_serial_port.sv
// Serial configuration port: pin filtering and 16-bit frame handling
`include "mdc_defs.svh"
module mdc_serial_port
   import mdc_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_sdi,
   output logic spi_sdo,
   output logic spi_sdo_oe,
   mdc_link_if.serial link
);
   logic [2:0] meta_reg; // First stage, read only by second
   logic [2:0] s2_reg; // Second stage
   logic [2:0] s3_reg; // Third stage
   logic [2:0] pin_reg; // Filtered pins: sdi, cs_n, sclk
   logic [2:0] prev_reg; // Filtered pins one cycle ago
   logic [4:0] cnt_reg; // Bits taken in this frame
   logic [6:0] rx_reg; // Shifted-in bits
   logic rd_reg; // Frame is a read
   logic [6:0] tx_reg; // Remaining read data bits
   logic sdo_reg; // Driven data bit
   logic sclk_rise;
   logic sclk_fall;
   logic cs_active;

   // Three-stage filter; a change counts once stages two and three agree
   always_ff @(posedge clock or negedge reset_n)
      if (!reset_n)
      begin
         // Idle levels: sclk low, cs_n high, so no false edge after reset
         meta_reg <= 3'h2;
         s2_reg <= 3'h2;
         s3_reg <= 3'h2;
         pin_reg <= 3'h2;
         prev_reg <= 3'h2;
      end
      else
      begin
         meta_reg <= {spi_sdi, spi_cs_n, spi_sclk};
         s2_reg <= meta_reg;
         s3_reg <= s2_reg;
         pin_reg <= (s2_reg & ~(s2_reg ^ s3_reg)) |
            (pin_reg & (s2_reg ^ s3_reg));
         prev_reg <= pin_reg;
      end

   assign cs_active = ~pin_reg[1];
   assign sclk_rise = cs_active & pin_reg[0] & ~prev_reg[0];
   assign sclk_fall = cs_active & ~pin_reg[0] & prev_reg[0];
   // Handshake-style enable: drive only while selected
   assign spi_sdo_oe = cs_active;
   assign spi_sdo = sdo_reg;

   // Input shifting, header decode and write strobe
   always_ff @(posedge clock or negedge reset_n)
      if (!reset_n)
      begin
         cnt_reg <= 5'h00;
         rx_reg <= 7'h00;
         rd_reg <= 1'b0;
         link.addr <= 6'h00;
         link.wr_en <= 1'b0;
         link.wr_data <= 8'h00;
      end
      else
      begin
         link.wr_en <= 1'b0;
         if (!cs_active)
            cnt_reg <= 5'h00; // Early deselect drops the frame
         else if (sclk_rise && cnt_reg < 5'(`MDC_FRAME_BITS))
         begin
            rx_reg <= {rx_reg[5:0], pin_reg[2]};
            cnt_reg <= cnt_reg + 5'h01;
            if (cnt_reg == 5'(`MDC_HDR_BITS - 1))
            begin
               rd_reg <= rx_reg[6];
               link.addr <= rx_reg[5:0]; // Last header bit is parity
            end
            if (cnt_reg == 5'(`MDC_FRAME_BITS - 1) && !rd_reg)
            begin
               link.wr_en <= 1'b1;
               link.wr_data <= {rx_reg, pin_reg[2]};
            end
         end
      end

   // Output shifting; header time returns a zero status byte
   always_ff @(posedge clock or negedge reset_n)
      if (!reset_n)
      begin
         tx_reg <= 7'h00;
         sdo_reg <= 1'b0;
      end
      else if (!cs_active)
         sdo_reg <= 1'b0;
      else if (sclk_fall && cnt_reg == 5'(`MDC_HDR_BITS))
      begin
         sdo_reg <= link.rd_data[7];
         tx_reg <= link.rd_data[6:0];
      end
      else if (sclk_fall && cnt_reg > 5'(`MDC_HDR_BITS))
      begin
         sdo_reg <= tx_reg[6];
         tx_reg <= {tx_reg[5:0], 1'b0};
      end

   // Write strobe only after a whole write frame
   frame_write_a: assert property (@(posedge clock) disable iff (!reset_n)
      link.wr_en |-> $past(cnt_reg) == 5'(`MDC_FRAME_BITS - 1) && !rd_reg)
      else $error("write strobe without complete write frame");
   // Strobe lasts one cycle
   strobe_width_a: assert property (@(posedge clock) disable iff (!reset_n)
      link.wr_en |=> !link.wr_en)
      else $error("write strobe longer than one cycle");
endmodule

// >>> mdc_control_regs_note_end.sv
// Holds no logic; the bank lives in the other design files

// >>> tb_top.sv
// Self-checking bench for the motor driver control register bank
`include "mdc_defs.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // Clock, reset and pin stimulus
   logic clock, reset_n, spi_sclk, spi_cs_n, spi_sdi, pwm_in;
   logic overcurrent_raw, supply_over_raw, temp_warning_raw;
   // Design outputs
   logic spi_sdo, spi_sdo_oe, fault_output_n, full_duty_40k;
   logic overvoltage_level_22v, overvoltage_shutdown, driver_standby;
   logic overcurrent_level_24a, drive_shutdown, overcurrent_reported;
   logic limit_recirculation_coast, async_rectify_on, sync_rectify_on;
   logic buck_sequencing_on, buck_current_150ma, buck_run;
   logic [1:0] sense_amp_gain, buck_voltage_sel;
   // Score keeping
   int fail_count = 0;
   int num_checks = 0;
   // Short retry counts keep the run brief
   mdc_control_regs #(.RETRY_SHORT_CYCLES(50), .RETRY_LONG_CYCLES(200),
      .RETRY_W(26)) uut (.clock(clock), .reset_n(reset_n),
      .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
      .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .pwm_in(pwm_in),
      .overcurrent_raw(overcurrent_raw), .supply_over_raw(supply_over_raw),
      .temp_warning_raw(temp_warning_raw), .fault_output_n(fault_output_n),
      .full_duty_40k(full_duty_40k),
      .overvoltage_level_22v(overvoltage_level_22v),
      .overvoltage_shutdown(overvoltage_shutdown),
      .driver_standby(driver_standby),
      .overcurrent_level_24a(overcurrent_level_24a),
      .drive_shutdown(drive_shutdown),
      .overcurrent_reported(overcurrent_reported),
      .limit_recirculation_coast(limit_recirculation_coast),
      .async_rectify_on(async_rectify_on), .sync_rectify_on(sync_rectify_on),
      .sense_amp_gain(sense_amp_gain), .buck_sequencing_on(buck_sequencing_on),
      .buck_current_150ma(buck_current_150ma),
      .buck_voltage_sel(buck_voltage_sel), .buck_run(buck_run));
   // 125 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // Compare and count
   task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
      num_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Counts, verdict and end of run
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // One 16-bit frame; each sclk level held 8 clocks for the pin filter
   task automatic xfer(input logic [15:0] f, output logic [7:0] rd);
      rd = 8'h00;
      spi_cs_n <= 1'b0;
      repeat (8) @(posedge clock);
      chk("sdo enable", 16'h0001, {15'h0, spi_sdo_oe});
      for (int i = 15; i >= 0; i--)
      begin
         spi_sdi <= f[i];
         repeat (8) @(posedge clock);
         // Data bits are settled while sclk is low
         if (i < 8)
            rd[i] = spi_sdo;
         spi_sclk <= 1'b1;
         repeat (8) @(posedge clock);
         spi_sclk <= 1'b0;
      end
      repeat (8) @(posedge clock);
      spi_cs_n <= 1'b1;
      repeat (8) @(posedge clock);
      chk("sdo release", 16'h0000, {14'h0, spi_sdo_oe, spi_sdo});
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] r;
      xfer({1'b0, a, 1'b0, d}, r);
   endtask
   task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
      logic [7:0] r;
      xfer({1'b1, a, 9'h000}, r);
      chk("read", {8'h00, e}, {8'h00, r});
   endtask
   // Configuration outputs against the expected pattern e
   task automatic outs_chk(input logic [15:0] e);
      chk("outs", e, {2'b00, full_duty_40k,
         overvoltage_level_22v, driver_standby, overcurrent_level_24a,
         limit_recirculation_coast, async_rectify_on, sync_rectify_on,
         sense_amp_gain, buck_current_150ma, buck_voltage_sel,
         buck_sequencing_on, buck_run});
   endtask
   // Overcurrent held for len cycles, then settle
   task automatic oc_run(input int len);
      overcurrent_raw <= 1'b1;
      repeat (len) @(posedge clock);
      overcurrent_raw <= 1'b0;
      repeat (4) @(posedge clock);
   endtask
   // Bounded wait for the shutdown level v
   task automatic wait_ds(input logic v, input int bound, output int n);
      n = 0;
      while (drive_shutdown !== v)
      begin
         if (n == bound)
         begin
            chk("wait", 16'h0001, 16'h0000);
            give_verdict();
         end
         @(posedge clock);
         n++;
      end
   endtask
   // Reset values, masks, read-only zeros and unmapped space
   task automatic t_regs;
      logic [7:0] d;
      rd_chk(6'h05, `MDC_RST_SUPPLY);
      rd_chk(6'h06, `MDC_RST_OC);
      rd_chk(6'h07, `MDC_RST_LIMIT);
      rd_chk(6'h08, `MDC_RST_BUCK);
      rd_chk(6'h09, `MDC_RST_HALL);
      outs_chk(16'h0003);
      for (int k = 0; k < 2; k++)
      begin
         d = (k == 0) ? 8'hFF : 8'h00;
         wr(6'h05, d);
         wr(6'h06, d);
         wr(6'h07, d);
         wr(6'h08, d);
         wr(6'h09, d);
         rd_chk(6'h05, d & `MDC_WMASK_SUPPLY);
         rd_chk(6'h06, d & `MDC_WMASK_OC);
         rd_chk(6'h07, d & `MDC_WMASK_LIMIT);
         rd_chk(6'h08, d & `MDC_WMASK_BUCK);
         rd_chk(6'h09, d & `MDC_WMASK_HALL);
         outs_chk(d[0] ? 16'h3FFC : 16'h0003);
      end
      // Distinct patterns catch swapped fields and bits
      for (int k = 0; k < 2; k++)
      begin
         wr(6'h05, k ? 8'h08 : 8'h10);
         wr(6'h06, k ? 8'h80 : 8'h04);
         wr(6'h07, k ? 8'h0A : 8'h45);
         wr(6'h08, k ? 8'h1D : 8'h02);
         outs_chk(k ? 16'h1958 : 16'h26A7);
      end
      wr(6'h0A, 8'hFF);
      rd_chk(6'h0A, 8'h00);
      rd_chk(6'h04, 8'h00);
      $display("test regs done");
   endtask
   // Temperature warning reporting and overvoltage enable
   task automatic t_supply;
      wr(6'h05, 8'h01);
      temp_warning_raw <= 1'b1;
      repeat (4) @(posedge clock);
      chk("warn on", 16'h0000, {15'h0, fault_output_n});
      wr(6'h05, 8'h00);
      chk("warn off", 16'h0001, {15'h0, fault_output_n});
      temp_warning_raw <= 1'b0;
      supply_over_raw <= 1'b1;
      repeat (4) @(posedge clock);
      chk("ov off", 16'h0000, {15'h0, overvoltage_shutdown});
      wr(6'h05, 8'h04);
      chk("ov on", 16'h0001, {15'h0, overvoltage_shutdown});
      supply_over_raw <= 1'b0;
      wr(6'h05, 8'h00);
      wr(6'h04, 8'h01);
      $display("test supply done");
   endtask
   // Deglitch, latch, clear, cycle release and report-only modes
   task automatic t_oc;
      int n;
      wr(6'h06, 8'h00);
      oc_run(20);
      chk("deg0 short", 16'h0000, {15'h0, drive_shutdown});
      oc_run(30);
      chk("latch", 16'h0001, {15'h0, drive_shutdown});
      wr(6'h04, 8'h01);
      chk("cleared", 16'h0000, {15'h0, drive_shutdown});
      rd_chk(6'h04, 8'h00);
      wr(6'h06, 8'h30);
      oc_run(180);
      chk("deg3 short", 16'h0000, {15'h0, drive_shutdown});
      oc_run(210);
      chk("deg3 trip", 16'h0001, {15'h0, drive_shutdown});
      wr(6'h04, 8'h01);
      // Codes 1 and 2: 75 and 157 cycles
      for (int k = 1; k < 3; k++)
      begin
         wr(6'h06, k == 1 ? 8'h10 : 8'h20);
         oc_run(k == 1 ? 70 : 150);
         chk("deg short", 16'h0000, {15'h0, drive_shutdown});
         oc_run(k == 1 ? 80 : 165);
         chk("deg trip", 16'h0001, {15'h0, drive_shutdown});
         wr(6'h04, 8'h01);
      end
      wr(6'h06, 8'h00);
      oc_run(30);
      pwm_in <= 1'b1;
      repeat (20) @(posedge clock);
      chk("no cycle clr", 16'h0001, {15'h0, drive_shutdown});
      pwm_in <= 1'b0;
      wr(6'h04, 8'h01);
      wr(6'h06, 8'h40);
      oc_run(30);
      pwm_in <= 1'b1;
      wait_ds(1'b0, 20, n);
      pwm_in <= 1'b0;
      wr(6'h06, 8'h01);
      oc_run(30);
      wait_ds(1'b0, 300, n);
      chk("retry short", 16'h0001, {15'h0, (n > 30 && n < 60)});
      wr(6'h06, 8'h09);
      oc_run(30);
      wait_ds(1'b0, 400, n);
      chk("retry long", 16'h0001, {15'h0, (n > 180 && n < 210)});
      // Drop the report left by the retry trips first
      wr(6'h04, 8'h01);
      wr(6'h06, 8'h02);
      oc_run(30);
      chk("report", 16'h0002, {14'h0, overcurrent_reported,
         drive_shutdown});
      wr(6'h04, 8'h01);
      chk("report clr", 16'h0000, {15'h0, overcurrent_reported});
      wr(6'h06, 8'h03);
      oc_run(30);
      chk("ignore", 16'h0000, {14'h0, overcurrent_reported,
         drive_shutdown});
      $display("test overcurrent done");
   endtask
   // Main sequence
   initial
   begin
      reset_n = 1'b0;
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_sdi = 1'b0;
      pwm_in = 1'b0;
      overcurrent_raw = 1'b0;
      supply_over_raw = 1'b0;
      temp_warning_raw = 1'b0;
      repeat (16) @(posedge clock);
      reset_n <= 1'b1;
      repeat (8) @(posedge clock);
      t_regs();
      t_supply();
      t_oc();
      give_verdict();
   end
endmodule
